// ==== pkg/wakeup_pkg.sv ====
// register map, field layout and timing constants for the wake-up timer block
package wakeup_pkg;
  // register addresses on the host register port
  localparam logic [5:0] ADDR_WAKEUP_TIMER_CONTROL = 6'h31;
  localparam logic [5:0] ADDR_AMPLITUDE_CONFIG     = 6'h32;
  localparam logic [5:0] ADDR_AMPLITUDE_REFERENCE  = 6'h33;
  localparam logic [5:0] ADDR_AMPLITUDE_AVERAGE    = 6'h34;
  localparam logic [5:0] ADDR_AMPLITUDE_RESULT     = 6'h35;
  localparam logic [5:0] ADDR_PHASE_CONFIG         = 6'h36;
  localparam logic [5:0] ADDR_PHASE_REFERENCE      = 6'h37;
  localparam logic [5:0] ADDR_PHASE_AVERAGE        = 6'h38;
  localparam logic [5:0] ADDR_PHASE_RESULT         = 6'h39;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // timing: step lengths in ms and the clock rate in kHz
  localparam int STEP_SHORT_MS = 10;
  localparam int STEP_LONG_MS  = 100;
  localparam int CLK_KHZ       = 250000;
  localparam int CYC_PER_SHORT_STEP = STEP_SHORT_MS * CLK_KHZ;
  localparam logic [7:0] LONG_STEP_MULT = 8'(STEP_LONG_MS / STEP_SHORT_MS);

  // average weight shift amounts 2, 3, 4, 5, for weights 4, 8, 16, 32
  localparam logic [2:0] SHIFT_W4  = 3'h2;
  localparam logic [2:0] SHIFT_W8  = 3'h3;
  localparam logic [2:0] SHIFT_W16 = 3'h4;
  localparam logic [2:0] SHIFT_W32 = 3'h5;

  // wake-up timer control layout, msb first
  typedef struct packed {
    logic       range_short;   // bit 7: 1 = 10 ms steps
    logic [2:0] timeout_code;  // bits 6..4
    logic       periodic_irq;  // bit 3
    logic       amplitude_chk; // bit 2
    logic       phase_chk;     // bit 1
    logic       unused0;       // bit 0, reads zero
  } wut_cfg_type;

  // amplitude / phase measurement configuration layout
  typedef struct packed {
    logic [3:0] delta;         // bits 7..4
    logic       include_irq;   // bit 3
    logic [1:0] avg_weight;    // bits 2..1
    logic       ref_source;    // bit 0: 1 = auto-average
  } meas_cfg_type;

  typedef enum logic { KIND_AMPLITUDE, KIND_PHASE } meas_kind_type;
endpackage

// ==== design/wakeup_timer_measure_compare.sv ====
// wake-up timer with amplitude and phase measurement supervision
`timescale 1ns/100ps

module wakeup_timer_measure_compare #(
  parameter int CYC_PER_STEP = wakeup_pkg::CYC_PER_SHORT_STEP
) (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       set_default,
  input  wire logic       wakeup_active,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            meas_start,
  output logic            meas_kind,
  input  wire logic       meas_valid,
  input  wire logic [7:0] meas_result,
  output logic            irq_timer,
  output logic            irq_amplitude,
  output logic            irq_phase,
  output logic            timer_expired
);

  typedef enum logic [1:0] { ST_IDLE, ST_AMP_WAIT, ST_PH_WAIT } seq_state_type;

  // new average = avg + (res - avg) / weight, arithmetic shift of a 10-bit signed difference
  function automatic logic [7:0] avg_update(input logic [7:0] avg, input logic [7:0] res,
                                            input logic [1:0] wsel);
    logic signed [9:0] diff;
    logic signed [9:0] step;
    logic [2:0]        sh;
    diff = $signed({2'b00, res}) - $signed({2'b00, avg});
    unique case (wsel)
      2'b00: sh = wakeup_pkg::SHIFT_W4;
      2'b01: sh = wakeup_pkg::SHIFT_W8;
      2'b10: sh = wakeup_pkg::SHIFT_W16;
      2'b11: sh = wakeup_pkg::SHIFT_W32;
    endcase
    step = diff >>> sh;
    avg_update = 8'($signed({2'b00, avg}) + step);
  endfunction

  // true when |res - ref| exceeds the 4-bit delta
  function automatic logic over_delta(input logic [7:0] res, input logic [7:0] ref_val,
                                      input logic [3:0] delta);
    logic [7:0] mag;
    mag = (res >= ref_val) ? 8'(res - ref_val) : 8'(ref_val - res);
    over_delta = (mag > {4'h0, delta});
  endfunction

  wakeup_pkg::wut_cfg_type  wut_cfg_ff;
  wakeup_pkg::meas_cfg_type amp_cfg_ff;
  wakeup_pkg::meas_cfg_type ph_cfg_ff;
  logic [7:0]               amp_ref_ff;
  logic [7:0]               amp_avg_ff;
  logic [7:0]               amp_res_ff;
  logic [7:0]               ph_ref_ff;
  logic [7:0]               ph_avg_ff;
  logic [7:0]               ph_res_ff;
  logic [31:0]              div_cnt_ff;
  logic [7:0]               step_cnt_ff;
  seq_state_type            state_ff;
  seq_state_type            nxt_state;
  logic                     ph_pending_ff;
  logic [7:0]               reg_rdata_ff;
  logic                     meas_start_ff;
  logic                     meas_kind_ff;
  logic                     irq_timer_ff;
  logic                     irq_amp_ff;
  logic                     irq_ph_ff;
  logic                     expired_ff;

  // clear condition shared by config and display registers
  wire clear_all = rst | set_default;

  // register write decode
  wire wr_wut     = reg_wr & (reg_addr == wakeup_pkg::ADDR_WAKEUP_TIMER_CONTROL);
  wire wr_amp_cfg = reg_wr & (reg_addr == wakeup_pkg::ADDR_AMPLITUDE_CONFIG);
  wire wr_amp_ref = reg_wr & (reg_addr == wakeup_pkg::ADDR_AMPLITUDE_REFERENCE);
  wire wr_ph_cfg  = reg_wr & (reg_addr == wakeup_pkg::ADDR_PHASE_CONFIG);
  wire wr_ph_ref  = reg_wr & (reg_addr == wakeup_pkg::ADDR_PHASE_REFERENCE);

  // configuration registers; bit 0 of the timer control has no function
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      wut_cfg_ff <= wakeup_pkg::wut_cfg_type'(wakeup_pkg::REG_RESET);
      amp_cfg_ff <= wakeup_pkg::meas_cfg_type'(wakeup_pkg::REG_RESET);
      ph_cfg_ff  <= wakeup_pkg::meas_cfg_type'(wakeup_pkg::REG_RESET);
      amp_ref_ff <= wakeup_pkg::REG_RESET;
      ph_ref_ff  <= wakeup_pkg::REG_RESET;
    end else begin
      if (wr_wut) begin
        wut_cfg_ff <= wakeup_pkg::wut_cfg_type'({reg_wdata[7:1], 1'b0});
      end
      if (wr_amp_cfg) begin
        amp_cfg_ff <= wakeup_pkg::meas_cfg_type'(reg_wdata);
      end
      if (wr_amp_ref) begin
        amp_ref_ff <= reg_wdata;
      end
      if (wr_ph_cfg) begin
        ph_cfg_ff <= wakeup_pkg::meas_cfg_type'(reg_wdata);
      end
      if (wr_ph_ref) begin
        ph_ref_ff <= reg_wdata;
      end
    end
  end

  // read mux; read-only and unmapped addresses ignore writes, unmapped read zero
  logic [7:0] rd_mux;
  always_comb begin
    unique case (reg_addr)
      wakeup_pkg::ADDR_WAKEUP_TIMER_CONTROL: rd_mux = wut_cfg_ff;
      wakeup_pkg::ADDR_AMPLITUDE_CONFIG:     rd_mux = amp_cfg_ff;
      wakeup_pkg::ADDR_AMPLITUDE_REFERENCE:  rd_mux = amp_ref_ff;
      wakeup_pkg::ADDR_AMPLITUDE_AVERAGE:    rd_mux = amp_avg_ff;
      wakeup_pkg::ADDR_AMPLITUDE_RESULT:     rd_mux = amp_res_ff;
      wakeup_pkg::ADDR_PHASE_CONFIG:         rd_mux = ph_cfg_ff;
      wakeup_pkg::ADDR_PHASE_REFERENCE:      rd_mux = ph_ref_ff;
      wakeup_pkg::ADDR_PHASE_AVERAGE:        rd_mux = ph_avg_ff;
      wakeup_pkg::ADDR_PHASE_RESULT:         rd_mux = ph_res_ff;
      default:                               rd_mux = wakeup_pkg::READ_ZERO;
    endcase
  end

  // read data held until the next read strobe; set-default clears it like reset
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      reg_rdata_ff <= wakeup_pkg::READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata_ff <= rd_mux;
    end
  end

  // 10 ms tick divider; a long step is ten ticks so both ranges share one divider
  wire div_wrap = (div_cnt_ff == 32'(CYC_PER_STEP - 1));
  wire tick     = wakeup_active & div_wrap;
  wire [7:0] ticks_per_step = wut_cfg_ff.range_short ? 8'h01 : wakeup_pkg::LONG_STEP_MULT;
  wire [7:0] ticks_total    = 8'(({5'h00, wut_cfg_ff.timeout_code} + 8'h01) * ticks_per_step);
  wire expiry = tick & (step_cnt_ff == 8'(ticks_total - 8'h01));

  // a control write restarts the timeout; otherwise a shorter new timeout could be overrun by the old count
  always_ff @(posedge mclk) begin
    if (clear_all | ~wakeup_active | wr_wut) begin
      div_cnt_ff <= 32'h0000_0000;
    end else begin
      div_cnt_ff <= div_wrap ? 32'h0000_0000 : 32'(div_cnt_ff + 32'h0000_0001);
    end
  end

  // step counter restarts at each expiry, giving a periodic timeout
  always_ff @(posedge mclk) begin
    if (clear_all | ~wakeup_active | wr_wut) begin
      step_cnt_ff <= 8'h00;
    end else if (expiry) begin
      step_cnt_ff <= 8'h00;
    end else if (tick) begin
      step_cnt_ff <= 8'(step_cnt_ff + 8'h01);
    end
  end

  // comparison of the incoming result against the selected reference
  wire [7:0] amp_ref_sel = amp_cfg_ff.ref_source ? amp_avg_ff : amp_ref_ff;
  wire [7:0] ph_ref_sel  = ph_cfg_ff.ref_source ? ph_avg_ff : ph_ref_ff;
  wire amp_over = over_delta(meas_result, amp_ref_sel, amp_cfg_ff.delta);
  wire ph_over  = over_delta(meas_result, ph_ref_sel, ph_cfg_ff.delta);
  wire amp_done = meas_valid & (state_ff == ST_AMP_WAIT);
  wire ph_done  = meas_valid & (state_ff == ST_PH_WAIT);
  wire amp_fold = amp_done & (~amp_over | amp_cfg_ff.include_irq);
  wire ph_fold  = ph_done & (~ph_over | ph_cfg_ff.include_irq);
  wire [7:0] amp_avg_nxt = avg_update(amp_avg_ff, meas_result, amp_cfg_ff.avg_weight);
  wire [7:0] ph_avg_nxt  = avg_update(ph_avg_ff, meas_result, ph_cfg_ff.avg_weight);

  // result and average displays, cleared with the configuration
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      amp_res_ff <= wakeup_pkg::REG_RESET;
      amp_avg_ff <= wakeup_pkg::REG_RESET;
      ph_res_ff  <= wakeup_pkg::REG_RESET;
      ph_avg_ff  <= wakeup_pkg::REG_RESET;
    end else begin
      if (amp_done) begin
        amp_res_ff <= meas_result;
      end
      if (amp_fold) begin
        amp_avg_ff <= amp_avg_nxt;
      end
      if (ph_done) begin
        ph_res_ff <= meas_result;
      end
      if (ph_fold) begin
        ph_avg_ff <= ph_avg_nxt;
      end
    end
  end

  // measurement sequencer: amplitude first, then phase; an expiry while busy is dropped
  wire go_amp = expiry & wut_cfg_ff.amplitude_chk;
  wire go_ph  = expiry & wut_cfg_ff.phase_chk;
  wire idle   = (state_ff == ST_IDLE);
  wire start_ph_now  = (idle & go_ph & ~go_amp) | (amp_done & ph_pending_ff);
  wire start_amp_now = idle & go_amp;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (go_amp) begin
          nxt_state = ST_AMP_WAIT;
        end else if (go_ph) begin
          nxt_state = ST_PH_WAIT;
        end
      end
      ST_AMP_WAIT: begin
        if (meas_valid) begin
          nxt_state = ph_pending_ff ? ST_PH_WAIT : ST_IDLE;
        end
      end
      ST_PH_WAIT: begin
        if (meas_valid) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // sequencer state and start strobe to the front end
  always_ff @(posedge mclk) begin
    if (clear_all | ~wakeup_active) begin
      state_ff      <= ST_IDLE;
      ph_pending_ff <= 1'b0;
      meas_start_ff <= 1'b0;
      meas_kind_ff  <= wakeup_pkg::KIND_AMPLITUDE;
    end else begin
      state_ff      <= nxt_state;
      meas_start_ff <= start_amp_now | start_ph_now;
      if (start_amp_now) begin
        ph_pending_ff <= go_ph; // phase follows once amplitude returns
        meas_kind_ff  <= wakeup_pkg::KIND_AMPLITUDE;
      end else if (start_ph_now) begin
        ph_pending_ff <= 1'b0;
        meas_kind_ff  <= wakeup_pkg::KIND_PHASE;
      end
    end
  end

  // interrupt pulses toward the device interrupt register
  always_ff @(posedge mclk) begin
    if (clear_all) begin
      irq_timer_ff <= 1'b0;
      irq_amp_ff   <= 1'b0;
      irq_ph_ff    <= 1'b0;
      expired_ff   <= 1'b0;
    end else begin
      irq_timer_ff <= expiry & wut_cfg_ff.periodic_irq;
      irq_amp_ff   <= amp_done & amp_over;
      irq_ph_ff    <= ph_done & ph_over;
      expired_ff   <= expiry;
    end
  end

  assign reg_rdata     = reg_rdata_ff;
  assign meas_start    = meas_start_ff;
  assign meas_kind     = meas_kind_ff;
  assign irq_timer     = irq_timer_ff;
  assign irq_amplitude = irq_amp_ff;
  assign irq_phase     = irq_ph_ff;
  assign timer_expired = expired_ff;

endmodule

// ==== sim/wakeup_timer_measure_compare_properties.sv ====
// port-level assertions for the wake-up timer block
`timescale 1ns/100ps
module wakeup_props #(
  parameter int CYC_PER_STEP = 10
) (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       set_default,
  input wire logic       wakeup_active,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [5:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       meas_start,
  input wire logic       meas_kind,
  input wire logic       meas_valid,
  input wire logic [7:0] meas_result,
  input wire logic       irq_timer,
  input wire logic       irq_amplitude,
  input wire logic       irq_phase,
  input wire logic       timer_expired
);
  int unsigned gap_ff;
  logic        seen_ff;
  // any timer restart voids the spacing history, so only clean gaps are judged
  always_ff @(posedge mclk) begin
    if (rst || set_default || !wakeup_active || (reg_wr && reg_addr == wakeup_pkg::ADDR_WAKEUP_TIMER_CONTROL)) begin
      gap_ff  <= 0;
      seen_ff <= 1'b0;
    end else begin
      gap_ff  <= timer_expired ? 0 : gap_ff + 1;
      seen_ff <= seen_ff | timer_expired;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  tmr_irq_a: assert property (irq_timer |-> timer_expired)
    else $error("timer irq without expiry");
  exp_grid_a: assert property (timer_expired && seen_ff |-> (gap_ff + 1) % CYC_PER_STEP == 0 && gap_ff < 80 * CYC_PER_STEP)
    else $error("expiry spacing off the step grid");
  amp_irq_a: assert property (irq_amplitude |-> $past(meas_valid) && !$past(meas_kind))
    else $error("amplitude irq without amplitude result");
  ph_irq_a: assert property (irq_phase |-> $past(meas_valid) && $past(meas_kind))
    else $error("phase irq without phase result");
  start_cause_a: assert property (meas_start |-> timer_expired || $past(timer_expired) || $past(meas_valid))
    else $error("measurement start without cause");
  kind_hold_a: assert property (!meas_start && !$past(set_default) |-> $stable(meas_kind))
    else $error("measurement kind moved without start");
  rdata_hold_a: assert property (!$past(reg_rd) && !$past(set_default) |-> $stable(reg_rdata))
    else $error("read data moved without read");
  ref_rdbk_a: assert property (reg_wr && reg_addr == wakeup_pkg::ADDR_AMPLITUDE_REFERENCE && !set_default ##1
    reg_rd && reg_addr == wakeup_pkg::ADDR_AMPLITUDE_REFERENCE && !set_default |=> reg_rdata == $past(reg_wdata, 2))
    else $error("reference did not read back");
  sd_clear_a: assert property (set_default |=> reg_rdata == 8'h00 && !meas_start && !irq_timer && !irq_amplitude && !irq_phase)
    else $error("set-default left outputs active");
endmodule

// ==== sim/wakeup_timer_measure_compare_bench.sv ====
// self-checking bench for the wake-up timer block
`timescale 1ns/100ps
module wakeup_timer_measure_compare_bench;
  localparam int CYC = 10;
  logic       mclk, rst, set_default, wakeup_active, reg_wr, reg_rd, meas_valid;
  int         owed;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, meas_result, ra, rp, d;
  logic       meas_start, meas_kind, irq_timer, irq_amplitude, irq_phase, timer_expired;
  int         n_fail, comparisons, cycles;
  logic [7:0] avg [2];
  logic [7:0] refv [2];
  logic [7:0] corner [4] = '{8'h85, 8'h86, 8'h7B, 8'h7A};
  wakeup_pkg::meas_cfg_type cfg [2];
  wakeup_timer_measure_compare #(.CYC_PER_STEP(CYC)) wakeup_timer_measure_compare_inst (
    .mclk(mclk), .rst(rst), .set_default(set_default), .wakeup_active(wakeup_active), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_start(meas_start),
    .meas_kind(meas_kind), .meas_valid(meas_valid), .meas_result(meas_result), .irq_timer(irq_timer),
    .irq_amplitude(irq_amplitude), .irq_phase(irq_phase), .timer_expired(timer_expired));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic final_report();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard sized well above the whole sequence
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 8000) begin
      n_fail++;
      final_report();
    end
  end
  // every start owes one answer, even one raised while the bench was busy elsewhere
  always @(negedge mclk) begin
    if (meas_start === 1'b1) owed++;
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpb(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  // register tasks are entered just after a rising edge and leave on one
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    cmp8(reg_rdata, e);
    @(posedge mclk);
  endtask
  // write immediately followed by a read of the same place
  task automatic wrrd(input logic [5:0] a, input logic [7:0] v, input logic [7:0] e);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr <= 1'b0;
    rd(a, e);
  endtask
  // spacing of the 2nd and 3rd expiry after a control write
  task automatic period(input logic [7:0] c);
    int t;
    wr(wakeup_pkg::ADDR_WAKEUP_TIMER_CONTROL, c);
    for (int p = 0; p < 3; p++) begin
      t = 0;
      do begin
        @(negedge mclk);
        t++;
      end while (timer_expired !== 1'b1 && t < 2000);
    end
    cmpb(irq_timer, c[3]);
    cmp8(8'(t / CYC), 8'((int'(c[6:4]) + 1) * (c[7] ? 1 : 10)));
    cmpb(t % CYC == 0, 1'b1);
    @(posedge mclk);
  endtask
  // plays the front end for one measurement; phase start may already be up
  task automatic round(input int k, input logic [7:0] r);
    logic [7:0] rf;
    logic       hit;
    int         n;
    n = 0;
    while (owed == 0 && n < 300) begin
      @(negedge mclk);
      n++;
    end
    owed--;
    cmpb(n < 300, 1'b1);
    cmpb(meas_kind, k[0]);
    repeat ($urandom_range(3)) @(posedge mclk);
    @(posedge mclk);
    meas_valid  <= 1'b1;
    meas_result <= r;
    @(posedge mclk);
    meas_valid <= 1'b0;
    @(negedge mclk);
    rf  = cfg[k].ref_source ? avg[k] : refv[k];
    hit = (r > rf ? r - rf : rf - r) > cfg[k].delta;
    cmpb(k ? irq_phase : irq_amplitude, hit);
    if (!hit || cfg[k].include_irq) avg[k] = avg[k] + 8'((int'(r) - int'(avg[k])) >>> (cfg[k].avg_weight + 2));
    @(posedge mclk);
  endtask
  initial begin
    {rst, set_default, wakeup_active, reg_wr, reg_rd, meas_valid} = 6'h20;
    {reg_addr, reg_wdata, meas_result} = 22'h0;
    {n_fail, comparisons, cycles, owed} = 0;
    avg = '{8'h00, 8'h00};
    void'($urandom(32'hE65A));
    repeat (4) @(posedge mclk);
    rst           <= 1'b0;
    wakeup_active <= 1'b1;
    for (int a = 8'h30; a <= 8'h3A; a++) rd(6'(a), 8'h00);
    wrrd(wakeup_pkg::ADDR_WAKEUP_TIMER_CONTROL, 8'hF9, 8'hF8);
    for (int a = 8'h32; a <= 8'h39; a++) begin
      d = 8'($urandom);
      wrrd(6'(a), d, (a == 8'h34 || a == 8'h35 || a > 8'h37) ? 8'h00 : d);
    end
    period({1'b1, 3'($urandom), 1'b1, 3'h0});
    period(8'h10);
    wr(wakeup_pkg::ADDR_WAKEUP_TIMER_CONTROL, 8'hF6);
    // first passes sit on the delta boundary, later ones are random, weights cycle through all codes
    for (int i = 0; i < 16; i++) begin
      for (int k = 0; k < 2; k++) begin
        cfg[k]  = {i < 4 ? 4'h5 : 4'($urandom), 1'($urandom), 2'(i), i < 4 ? 1'b0 : 1'($urandom)};
        refv[k] = i < 4 ? 8'h80 : 8'($urandom);
        wr(k ? wakeup_pkg::ADDR_PHASE_CONFIG : wakeup_pkg::ADDR_AMPLITUDE_CONFIG, cfg[k]);
        wr(k ? wakeup_pkg::ADDR_PHASE_REFERENCE : wakeup_pkg::ADDR_AMPLITUDE_REFERENCE, refv[k]);
      end
      ra = i < 4 ? corner[i] : 8'($urandom);
      rp = i < 4 ? corner[3 - i] : 8'($urandom);
      round(0, ra);
      round(1, rp);
      rd(wakeup_pkg::ADDR_AMPLITUDE_RESULT, ra);
      rd(wakeup_pkg::ADDR_AMPLITUDE_AVERAGE, avg[0]);
      rd(wakeup_pkg::ADDR_PHASE_RESULT, rp);
      rd(wakeup_pkg::ADDR_PHASE_AVERAGE, avg[1]);
    end
    set_default <= 1'b1;
    @(posedge mclk);
    set_default <= 1'b0;
    for (int a = 8'h31; a <= 8'h39; a++) rd(6'(a), 8'h00);
    final_report();
  end
endmodule
bind wakeup_timer_measure_compare wakeup_props #(.CYC_PER_STEP(CYC_PER_STEP)) wakeup_props_inst (
  .mclk(mclk), .rst(rst), .set_default(set_default), .wakeup_active(wakeup_active), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_start(meas_start),
  .meas_kind(meas_kind), .meas_valid(meas_valid), .meas_result(meas_result), .irq_timer(irq_timer),
  .irq_amplitude(irq_amplitude), .irq_phase(irq_phase), .timer_expired(timer_expired));
